// *** rtl/irq_ctrl_consts.vh ***
// constants for the prioritised interrupt controller: register indices,
// reset values, field positions and service addresses
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define IDX_SPI_SUBEN 8'ha6
`define IDX_EN_LOW 8'ha8
`define IDX_PRI_LO 8'ha9
`define IDX_EN_HIGH 8'hb8
`define IDX_PRI_HI 8'hb9
`define IDX_FLAGS 8'hc0
`define IDX_PIN_CTL 8'hd0
`define IDX_STATUS 8'hd1

// reset values
`define RST_SPI_SUBEN 8'h01
`define RST_EN_LOW 8'h00
`define RST_PRI 8'h00
`define RST_EN_HIGH 8'h00
`define RST_FLAGS 8'h00
`define RST_PIN_CTL 4'h0

// writable masks: unused bits read as zero
`define MASK_SPI_SUBEN 8'h03
`define MASK_EN_LOW 8'hbf
`define MASK_EN_HIGH 8'hbf
`define MASK_PRI 8'h3f

// field positions
`define EN_GLOBAL 7
`define FLAG_EXT_RELOAD 7
`define FLAG_T2_OVF 6
`define FLAG_WAKEUP 5
`define FLAG_BUS_EVENT 4
`define FLAG_BUS_RESUME 3
`define FLAG_SPI 2
`define FLAG_RADIO 1
`define FLAG_CMD_READY 0
`define FLAGS_AUTO_CLEAR 8'h3e
`define SUBEN_MASTER 1
`define SUBEN_SLAVE 0
`define PIN_P03_HIGH 0
`define PIN_P03_EDGE 1
`define PIN_P04_HIGH 2
`define PIN_P04_EDGE 3

// service addresses
`define VEC_P03 16'h0003
`define VEC_T0 16'h000b
`define VEC_CIPHER 16'h0013
`define VEC_T1 16'h001b
`define VEC_SERIAL 16'h0023
`define VEC_T2 16'h002b
`define VEC_CMD_READY 16'h0043
`define VEC_RADIO 16'h004b
`define VEC_SPI 16'h0053
`define VEC_BUS_RESUME 16'h005b
`define VEC_BUS_EVENT 16'h0063
`define VEC_WAKEUP 16'h006b

`endif

// *** rtl/prioritized_interrupt_controller.v ***
// prioritised interrupt controller: fourteen request lines from sixteen
// sources, four priority levels in six groups, vectored hand-off to the core.
// assumes peripheral inputs come from logic on core_clk; pin inputs are async.
// the core pulses irq_take when it vectors and irq_return on handler exit.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "irq_ctrl_consts.vh"

module prioritized_interrupt_controller #(
	parameter ADR_W = 10
) (
	input wire core_clk,
	input wire rst_b,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire pin_p03,
	input wire pin_p04,
	input wire pin_p05,
	input wire cipher_ready_request,
	input wire timer_zero_overflow,
	input wire timer_one_overflow,
	input wire timer_two_overflow,
	input wire serial_receive_request,
	input wire serial_transmit_request,
	input wire radio_command_ready,
	input wire radio_event,
	input wire spi_master_done,
	input wire spi_slave_done,
	input wire bus_resume_request,
	input wire bus_event_request,
	input wire internal_wakeup_request,
	input wire irq_take,
	input wire irq_return,
	output reg irq_req_q,
	output reg [15:0] irq_vector_q,
	output reg [1:0] irq_level_q
);

	localparam NSRC = 14;
	// request line indices, also the fixed polling order
	localparam [3:0] S_P03 = 4'h0;
	localparam [3:0] S_T0 = 4'h1;
	localparam [3:0] S_CIPHER = 4'h2;
	localparam [3:0] S_T1 = 4'h3;
	localparam [3:0] S_RX = 4'h4;
	localparam [3:0] S_TX = 4'h5;
	localparam [3:0] S_T2 = 4'h6;
	localparam [3:0] S_EXT = 4'h7;
	localparam [3:0] S_CMD = 4'h8;
	localparam [3:0] S_RADIO = 4'h9;
	localparam [3:0] S_SPI = 4'ha;
	localparam [3:0] S_RESUME = 4'hb;
	localparam [3:0] S_EVENT = 4'hc;
	localparam [3:0] S_WAKE = 4'hd;

	reg [7:0] spi_suben_q;
	reg [7:0] en_low_q;
	reg [7:0] pri_lo_q;
	reg [7:0] en_high_q;
	reg [7:0] pri_hi_q;
	reg [7:0] flags_q;
	reg [7:0] flags_d;
	reg [3:0] pin_ctl_q;
	reg [3:0] in_service_q;
	reg [3:0] in_service_d;
	reg [3:0] sel_q;
	reg p03_latch_q;
	reg p04_latch_q;
	reg [2:0] pin_meta_q;
	reg [2:0] pin_sync_q;
	reg [2:0] pin_prev_q;
	reg radio_prev_q;
	reg master_prev_q;
	reg slave_prev_q;
	reg resume_prev_q;
	reg event_prev_q;
	reg wake_prev_q;
	reg [NSRC-1:0] req;
	reg [1:0] best_lvl;
	reg [3:0] best_idx;
	reg found;
	reg accept;
	reg [7:0] rd_val;
	integer i;

	wire bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// writes land at the acknowledge edge, where the master completes the cycle
	wire wr_go = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	wire [7:0] idx = wb_adr_i[9:2];
	wire take = irq_take & irq_req_q;

	// priority group of each request line
	function [2:0] group_of;
		input [3:0] s;
		begin
			case (s)
				S_P03, S_RADIO: group_of = 3'd0;
				S_T0, S_CMD: group_of = 3'd1;
				S_CIPHER, S_SPI: group_of = 3'd2;
				S_T1, S_RESUME: group_of = 3'd3;
				S_RX, S_TX, S_EVENT: group_of = 3'd4;
				default: group_of = 3'd5;
			endcase
		end
	endfunction

	// service address of each request line
	function [15:0] vector_of;
		input [3:0] s;
		begin
			case (s)
				S_P03: vector_of = `VEC_P03;
				S_T0: vector_of = `VEC_T0;
				S_CIPHER: vector_of = `VEC_CIPHER;
				S_T1: vector_of = `VEC_T1;
				S_RX, S_TX: vector_of = `VEC_SERIAL;
				S_T2, S_EXT: vector_of = `VEC_T2;
				S_CMD: vector_of = `VEC_CMD_READY;
				S_RADIO: vector_of = `VEC_RADIO;
				S_SPI: vector_of = `VEC_SPI;
				S_RESUME: vector_of = `VEC_BUS_RESUME;
				S_EVENT: vector_of = `VEC_BUS_EVENT;
				default: vector_of = `VEC_WAKEUP;
			endcase
		end
	endfunction

	// level of the highest handler in service
	function [1:0] top_level;
		input [3:0] m;
		begin
			if (m[3])
				top_level = 2'd3;
			else if (m[2])
				top_level = 2'd2;
			else if (m[1])
				top_level = 2'd1;
			else
				top_level = 2'd0;
		end
	endfunction

	// pins are asynchronous: two flops, then a third for edge detection
	always @(posedge core_clk) begin
		if (!rst_b) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
			pin_prev_q <= 3'h0;
		end else begin
			pin_meta_q <= {pin_p05, pin_p04, pin_p03};
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	// pin active level, low unless the polarity bit is set
	wire p03_act = pin_sync_q[0] ^ ~pin_ctl_q[`PIN_P03_HIGH];
	wire p03_was = pin_prev_q[0] ^ ~pin_ctl_q[`PIN_P03_HIGH];
	wire p04_act = pin_sync_q[1] ^ ~pin_ctl_q[`PIN_P04_HIGH];
	wire p04_was = pin_prev_q[1] ^ ~pin_ctl_q[`PIN_P04_HIGH];

	// edge events of peripheral sources
	wire radio_edge = radio_event ^ radio_prev_q;
	wire master_edge = (spi_master_done ^ master_prev_q) & spi_suben_q[`SUBEN_MASTER];
	wire slave_edge = (spi_slave_done ^ slave_prev_q) & spi_suben_q[`SUBEN_SLAVE];
	wire resume_rise = bus_resume_request & ~resume_prev_q;
	wire event_rise = bus_event_request & ~event_prev_q;
	wire wake_rise = internal_wakeup_request & ~wake_prev_q;

	// previous values for edge detection
	always @(posedge core_clk) begin
		if (!rst_b) begin
			radio_prev_q <= 1'b0;
			master_prev_q <= 1'b0;
			slave_prev_q <= 1'b0;
			resume_prev_q <= 1'b0;
			event_prev_q <= 1'b0;
			wake_prev_q <= 1'b0;
		end else begin
			radio_prev_q <= radio_event;
			master_prev_q <= spi_master_done;
			slave_prev_q <= spi_slave_done;
			resume_prev_q <= bus_resume_request;
			event_prev_q <= bus_event_request;
			wake_prev_q <= internal_wakeup_request;
		end
	end

	// request flag register: software write, vector auto clear, hardware set.
	// set is applied last so an event in the clearing cycle is never lost.
	always @* begin
		flags_d = flags_q;
		if (wr_go && idx == `IDX_FLAGS)
			flags_d = wb_dat_i[7:0];
		if (take) begin
			case (sel_q)
				S_RADIO: flags_d[`FLAG_RADIO] = 1'b0;
				S_SPI: flags_d[`FLAG_SPI] = 1'b0;
				S_RESUME: flags_d[`FLAG_BUS_RESUME] = 1'b0;
				S_EVENT: flags_d[`FLAG_BUS_EVENT] = 1'b0;
				S_WAKE: flags_d[`FLAG_WAKEUP] = 1'b0;
				default: flags_d = flags_d;
			endcase
		end
		if (pin_sync_q[2])
			flags_d[`FLAG_EXT_RELOAD] = 1'b1;
		if (timer_two_overflow)
			flags_d[`FLAG_T2_OVF] = 1'b1;
		if (wake_rise)
			flags_d[`FLAG_WAKEUP] = 1'b1;
		if (event_rise)
			flags_d[`FLAG_BUS_EVENT] = 1'b1;
		if (resume_rise)
			flags_d[`FLAG_BUS_RESUME] = 1'b1;
		if (master_edge || slave_edge)
			flags_d[`FLAG_SPI] = 1'b1;
		if (radio_edge)
			flags_d[`FLAG_RADIO] = 1'b1;
		if (radio_command_ready)
			flags_d[`FLAG_CMD_READY] = 1'b1;
	end

	// gated request per line; flags 7, 6 and 0 stay until software clears them
	always @* begin
		req = {NSRC{1'b0}};
		req[S_P03] = en_low_q[0] & (pin_ctl_q[`PIN_P03_EDGE] ? p03_latch_q : p03_act);
		req[S_T0] = en_low_q[1] & timer_zero_overflow;
		req[S_CIPHER] = en_low_q[2] & (~cipher_ready_request |
			(pin_ctl_q[`PIN_P04_EDGE] ? p04_latch_q : p04_act));
		req[S_T1] = en_low_q[3] & timer_one_overflow;
		req[S_RX] = en_low_q[4] & serial_receive_request;
		req[S_TX] = en_low_q[4] & serial_transmit_request;
		req[S_T2] = en_low_q[5] & flags_q[`FLAG_T2_OVF];
		req[S_EXT] = en_high_q[7] & flags_q[`FLAG_EXT_RELOAD];
		req[S_CMD] = en_high_q[0] & flags_q[`FLAG_CMD_READY];
		req[S_RADIO] = en_high_q[1] & flags_q[`FLAG_RADIO];
		req[S_SPI] = en_high_q[2] & flags_q[`FLAG_SPI];
		req[S_RESUME] = en_high_q[3] & flags_q[`FLAG_BUS_RESUME];
		req[S_EVENT] = en_high_q[4] & flags_q[`FLAG_BUS_EVENT];
		req[S_WAKE] = en_high_q[5] & flags_q[`FLAG_WAKEUP];
		if (!en_low_q[`EN_GLOBAL])
			req = {NSRC{1'b0}};
	end

	// winner: highest level, ties to the lowest line index
	always @* begin
		found = 1'b0;
		best_lvl = 2'd0;
		best_idx = 4'h0;
		for (i = 0; i < NSRC; i = i + 1) begin
			if (req[i] && (!found || {pri_hi_q[group_of(i[3:0])], pri_lo_q[group_of(i[3:0])]} > best_lvl)) begin
				found = 1'b1;
				best_lvl = {pri_hi_q[group_of(i[3:0])], pri_lo_q[group_of(i[3:0])]};
				best_idx = i[3:0];
			end
		end
		accept = found && (in_service_q == 4'h0 || best_lvl > top_level(in_service_q));
	end

	// in-service levels: return pops the top, take pushes the vectored level
	always @* begin
		in_service_d = in_service_q;
		if (irq_return)
			in_service_d[top_level(in_service_q)] = 1'b0;
		if (take)
			in_service_d[irq_level_q] = 1'b1;
	end

	// request to the core; dropped in the take cycle so it cannot repeat
	always @(posedge core_clk) begin
		if (!rst_b) begin
			irq_req_q <= 1'b0;
			irq_vector_q <= 16'h0000;
			irq_level_q <= 2'd0;
			sel_q <= 4'h0;
			in_service_q <= 4'h0;
		end else begin
			irq_req_q <= accept & ~take & ~irq_return;
			in_service_q <= in_service_d;
			if (!take) begin
				irq_vector_q <= vector_of(best_idx);
				irq_level_q <= best_lvl;
				sel_q <= best_idx;
			end
		end
	end

	// pin edge latches, armed only in edge mode so level activity leaves nothing stale
	always @(posedge core_clk) begin
		if (!rst_b) begin
			p03_latch_q <= 1'b0;
			p04_latch_q <= 1'b0;
		end else begin
			if (pin_ctl_q[`PIN_P03_EDGE] && p03_act && !p03_was)
				p03_latch_q <= 1'b1;
			else if (take && sel_q == S_P03)
				p03_latch_q <= 1'b0;
			if (pin_ctl_q[`PIN_P04_EDGE] && p04_act && !p04_was)
				p04_latch_q <= 1'b1;
			else if (take && sel_q == S_CIPHER)
				p04_latch_q <= 1'b0;
		end
	end

	// register writes, low byte lane only
	always @(posedge core_clk) begin
		if (!rst_b) begin
			spi_suben_q <= `RST_SPI_SUBEN;
			en_low_q <= `RST_EN_LOW;
			pri_lo_q <= `RST_PRI;
			en_high_q <= `RST_EN_HIGH;
			pri_hi_q <= `RST_PRI;
			flags_q <= `RST_FLAGS;
			pin_ctl_q <= `RST_PIN_CTL;
		end else begin
			flags_q <= flags_d;
			if (wr_go) begin
				case (idx)
					`IDX_SPI_SUBEN: spi_suben_q <= wb_dat_i[7:0] & `MASK_SPI_SUBEN;
					`IDX_EN_LOW: en_low_q <= wb_dat_i[7:0] & `MASK_EN_LOW;
					`IDX_PRI_LO: pri_lo_q <= wb_dat_i[7:0] & `MASK_PRI;
					`IDX_EN_HIGH: en_high_q <= wb_dat_i[7:0] & `MASK_EN_HIGH;
					`IDX_PRI_HI: pri_hi_q <= wb_dat_i[7:0] & `MASK_PRI;
					`IDX_PIN_CTL: pin_ctl_q <= wb_dat_i[3:0];
					default: pin_ctl_q <= pin_ctl_q;
				endcase
			end
		end
	end

	// read mux; unmapped indices read zero
	always @* begin
		case (idx)
			`IDX_SPI_SUBEN: rd_val = spi_suben_q;
			`IDX_EN_LOW: rd_val = en_low_q;
			`IDX_PRI_LO: rd_val = pri_lo_q;
			`IDX_EN_HIGH: rd_val = en_high_q;
			`IDX_PRI_HI: rd_val = pri_hi_q;
			`IDX_FLAGS: rd_val = flags_q;
			`IDX_PIN_CTL: rd_val = {4'h0, pin_ctl_q};
			`IDX_STATUS: rd_val = {irq_req_q, 3'h0, in_service_q};
			default: rd_val = 8'h00;
		endcase
	end

	// single-cycle wishbone answer; every address is acknowledged
	always @(posedge core_clk) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_go;
			if (bus_go && !wb_we_i)
				wb_dat_o <= {24'h000000, rd_val};
		end
	end

endmodule // prioritized_interrupt_controller

// *** sim/irq_ctrl_chk_sva.sv ***
// checker for the interrupt controller ports: bus answer, gate, vectoring
// assumes only the top ports are seen; shadows the gate and in-service levels
`timescale 1ns/1ps
`include "irq_ctrl_consts.vh"
module irq_ctrl_chk #(
	parameter ADR_W = 10
) (
	input wire core_clk,
	input wire rst_b,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [ADR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	input wire irq_take,
	input wire irq_return,
	input wire irq_req_q,
	input wire [15:0] irq_vector_q,
	input wire [1:0] irq_level_q
);
	reg gate_q;
	reg [3:0] busy_q;
	wire wr_hit = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
	wire [1:0] top = busy_q[3] ? 2'h3 : busy_q[2] ? 2'h2 : busy_q[1] ? 2'h1 : 2'h0;
	// the gate shadow follows writes at the acknowledge edge; the gate check allows
	// one cycle for the registered request to fall
	always @(posedge core_clk) begin
		if (!rst_b) begin
			gate_q <= 1'b0;
			busy_q <= 4'h0;
		end else begin
			if (wr_hit && wb_adr_i[9:2] == `IDX_EN_LOW)
				gate_q <= wb_dat_i[`EN_GLOBAL];
			// pop then push, as a return and a take may meet in one cycle
			if (irq_return)
				busy_q[top] <= 1'b0;
			if (irq_take && irq_req_q)
				busy_q[irq_level_q] <= 1'b1;
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_gate_off: assert property (!gate_q && !$past(gate_q) |-> !irq_req_q)
		else $error("request while globally disabled");
	chk_take_clears: assert property (irq_take && irq_req_q |=> !irq_req_q)
		else $error("request stayed after take");
	chk_return_quiet: assert property (irq_return |=> !irq_req_q)
		else $error("request right after return");
	chk_vector_known: assert property (irq_req_q |-> irq_vector_q inside {`VEC_P03, `VEC_T0,
		`VEC_CIPHER, `VEC_T1, `VEC_SERIAL, `VEC_T2, `VEC_CMD_READY, `VEC_RADIO, `VEC_SPI,
		`VEC_BUS_RESUME, `VEC_BUS_EVENT, `VEC_WAKEUP})
		else $error("vector not a service address");
	chk_level_above: assert property (irq_req_q && busy_q != 4'h0 |-> irq_level_q > top)
		else $error("request not above in-service level");
endmodule // irq_ctrl_chk

bind prioritized_interrupt_controller irq_ctrl_chk #(.ADR_W(ADR_W)) i_irq_ctrl_chk (.core_clk(core_clk),
	.rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .irq_take(irq_take),
	.irq_return(irq_return), .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q), .irq_level_q(irq_level_q));

// *** sim/core_model.sv ***
// core stand-in: takes an offered vector after a varying wait
// assumes the bench gates acceptance and asks for handler returns
`timescale 1ns/1ps
module core_model (
	input wire core_clk,
	input wire rst_b,
	input wire irq_req_q,
	input wire [15:0] irq_vector_q,
	input wire [1:0] irq_level_q,
	input wire accept,
	input wire ret,
	output reg irq_take,
	output reg irq_return,
	output reg [15:0] got_vec,
	output reg [1:0] got_lvl,
	output reg [7:0] takes
);
	reg [1:0] wait_q;
	// wait follows the take count so prompt and slow answers both occur
	always @(posedge core_clk) begin
		if (!rst_b) begin
			irq_take <= 1'b0;
			irq_return <= 1'b0;
			got_vec <= 16'h0000;
			got_lvl <= 2'h0;
			takes <= 8'h00;
			wait_q <= 2'h0;
		end else begin
			irq_return <= ret;
			irq_take <= 1'b0;
			// a take against a withdrawn request is ignored by the controller too
			if (irq_take && irq_req_q) begin
				got_vec <= irq_vector_q;
				got_lvl <= irq_level_q;
				takes <= takes + 8'h01;
				wait_q <= 2'h0;
			end else if (irq_req_q && accept) begin
				if (wait_q == takes[1:0])
					irq_take <= 1'b1;
				else
					wait_q <= wait_q + 2'h1;
			end else begin
				wait_q <= 2'h0;
			end
		end
	end
endmodule // core_model

// *** sim/prioritized_interrupt_controller_bench.sv ***
// bench for the interrupt controller: register access and vectoring
// assumes core_model answers the request side; sources driven from here
`timescale 1ns/1ps
module prioritized_interrupt_controller_bench;
	reg core_clk = 1'b0;
	reg rst_b = 1'b0;
	reg cyc = 1'b0;
	reg we = 1'b0;
	reg [9:0] adr = 10'h000;
	reg [31:0] wd = 32'h0;
	reg [15:0] drv = 16'h8005;
	reg accept = 1'b0;
	reg ret = 1'b0;
	reg [7:0] v;
	reg [7:0] t_s;
	reg [23:0] row;
	wire [31:0] rd;
	wire ack, take, rtn_w, req;
	wire [15:0] vec, got_vec;
	wire [1:0] lvl, got_lvl;
	wire [7:0] takes;
	integer fail_count = 0;
	integer checked = 0;
	integer k;
	// register index, reset value and readable mask per row; last row is unmapped
	function [23:0] reg_row(input integer r);
		begin
			case (r)
				0: reg_row = 24'ha6_01_03;
				1: reg_row = 24'ha8_00_bf;
				2: reg_row = 24'ha9_00_3f;
				3: reg_row = 24'hb8_00_bf;
				4: reg_row = 24'hb9_00_3f;
				5: reg_row = 24'hc0_00_ff;
				default: reg_row = 24'h10_00_00;
			endcase
		end
	endfunction
	// expected service address for each drv bit
	function [15:0] vec_want(input integer s);
		begin
			case (s)
				0: vec_want = 16'h0003;
				1: vec_want = 16'h000b;
				2, 15: vec_want = 16'h0013;
				3: vec_want = 16'h001b;
				4, 5: vec_want = 16'h0023;
				6, 7: vec_want = 16'h002b;
				8: vec_want = 16'h0043;
				9: vec_want = 16'h004b;
				10, 11: vec_want = 16'h0053;
				12: vec_want = 16'h005b;
				13: vec_want = 16'h0063;
				default: vec_want = 16'h006b;
			endcase
		end
	endfunction
	// drv bits: pins and sources in poll order, except pin_p04 last at bit 15; idle has the active-low ones high
	prioritized_interrupt_controller #(.ADR_W(10)) i_prioritized_interrupt_controller (
		.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
		.pin_p03(drv[0]), .timer_zero_overflow(drv[1]), .cipher_ready_request(drv[2]),
		.timer_one_overflow(drv[3]), .serial_receive_request(drv[4]), .serial_transmit_request(drv[5]),
		.timer_two_overflow(drv[6]), .pin_p05(drv[7]), .radio_command_ready(drv[8]), .radio_event(drv[9]),
		.spi_master_done(drv[10]), .spi_slave_done(drv[11]), .bus_resume_request(drv[12]),
		.bus_event_request(drv[13]), .internal_wakeup_request(drv[14]), .pin_p04(drv[15]),
		.irq_take(take), .irq_return(rtn_w), .irq_req_q(req), .irq_vector_q(vec), .irq_level_q(lvl));
	core_model i_core_model (.core_clk(core_clk), .rst_b(rst_b), .irq_req_q(req), .irq_vector_q(vec),
		.irq_level_q(lvl), .accept(accept), .ret(ret), .irq_take(take), .irq_return(rtn_w),
		.got_vec(got_vec), .got_lvl(got_lvl), .takes(takes));
	initial forever #20 core_clk = ~core_clk;
	// one classic cycle; read data lands in v
	task bus(input [7:0] idx, input w, input [7:0] d);
		integer n;
		begin
			@(posedge core_clk);
			cyc <= 1'b1;
			we <= w;
			adr <= {idx, 2'b00};
			wd <= {24'h0, d};
			n = 0;
			do begin
				@(posedge core_clk);
				n = n + 1;
			end while (ack !== 1'b1 && n < 20);
			v = rd[7:0];
			cyc <= 1'b0;
			if (n >= 20) fail_count = fail_count + 1;
		end
	endtask
	task check(input [17:0] seen, input [17:0] want);
		begin
			checked = checked + 1;
			if (seen !== want) begin
				fail_count = fail_count + 1;
				$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
			end
		end
	endtask
	// wait until the core takes a new vector, then stop it taking more
	task serve(input [7:0] n0);
		integer n;
		begin
			n = 0;
			while (takes === n0 && n < 100) begin
				@(posedge core_clk);
				n = n + 1;
			end
			accept <= 1'b0;
			if (n >= 100) fail_count = fail_count + 1;
		end
	endtask
	task rtn;
		begin
			@(posedge core_clk);
			ret <= 1'b1;
			@(posedge core_clk);
			ret <= 1'b0;
			repeat (2) @(posedge core_clk);
		end
	endtask
	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", checked, fail_count);
			if (fail_count == 0 && checked > 0) begin
				$display("No errors found");
			end else begin
				$display("Errors were found");
			end
			$finish;
		end
	endtask
	initial begin
		repeat (50000) @(posedge core_clk);
		fail_count = fail_count + 1;
		print_verdict;
	end
	initial begin
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		// reset values, writable bits, unmapped index reads zero
		for (k = 0; k < 7; k = k + 1) begin
			row = reg_row(k);
			bus(row[23:16], 1'b0, 8'h00);
			check(v, row[15:8]);
			bus(row[23:16], 1'b1, 8'hff);
			bus(row[23:16], 1'b0, 8'h00);
			check(v, row[7:0]);
			bus(row[23:16], 1'b1, 8'h00);
		end
		// radio event held off by the global gate, then vectored
		accept <= 1'b1;
		bus(8'hb8, 1'b1, 8'h02);
		drv[9] <= ~drv[9];
		repeat (10) @(posedge core_clk);
		check(takes, 0);
		bus(8'hc0, 1'b0, 8'h00);
		check(v, 8'h02);
		bus(8'ha8, 1'b1, 8'h80);
		serve(8'h00);
		check(got_vec, 16'h004b);
		bus(8'hc0, 1'b0, 8'h00);
		check(v, 8'h00);
		rtn;
		// every source alone; edge-on-both sources stay toggled
		bus(8'ha8, 1'b1, 8'hbf);
		bus(8'hb8, 1'b1, 8'hbf);
		bus(8'ha6, 1'b1, 8'h03);
		for (k = 0; k < 16; k = k + 1) begin
			accept <= 1'b1;
			drv[k] <= ~drv[k];
			serve(takes);
			check(got_vec, vec_want(k));
			if (k < 9 || k > 11) drv[k] <= ~drv[k];
			repeat (4) @(posedge core_clk);
			bus(8'hc0, 1'b1, 8'h00);
			rtn;
		end
		// equal levels by poll order, then preemption by higher levels only
		drv[1] <= 1'b1;
		drv[9] <= ~drv[9];
		repeat (6) @(posedge core_clk);
		accept <= 1'b1;
		serve(takes);
		check(got_vec, 16'h000b);
		bus(8'ha9, 1'b1, 8'h01);
		accept <= 1'b1;
		serve(takes);
		check({got_lvl, got_vec}, {2'h1, 16'h004b});
		t_s = takes;
		@(posedge core_clk);
		accept <= 1'b1;
		repeat (10) @(posedge core_clk);
		check(takes, t_s);
		bus(8'hb9, 1'b1, 8'h02);
		serve(t_s);
		check({got_lvl, got_vec}, {2'h2, 16'h000b});
		drv[1] <= 1'b0;
		repeat (3) rtn;
		// master completion gated off; wakeup flagged while disabled
		bus(8'hb8, 1'b1, 8'h04);
		bus(8'ha6, 1'b1, 8'h01);
		t_s = takes;
		accept <= 1'b1;
		drv[10] <= ~drv[10];
		drv[14] <= 1'b1;
		repeat (10) @(posedge core_clk);
		check(takes, t_s);
		bus(8'hc0, 1'b0, 8'h00);
		check(v[5], 1'b1);
		check(v[2], 1'b0);
		// P0.3 as active-high edge source: the falling edge is ignored, the rising one vectors
		bus(8'hd0, 1'b1, 8'h03);
		drv[0] <= 1'b0;
		repeat (8) @(posedge core_clk);
		check(takes, t_s);
		drv[0] <= 1'b1;
		serve(t_s);
		check(got_vec, 16'h0003);
		rtn;
		// the latch was cleared on vectoring, so nothing comes back
		t_s = takes;
		@(posedge core_clk);
		accept <= 1'b1;
		repeat (10) @(posedge core_clk);
		check(takes, t_s);
		print_verdict;
	end
endmodule // prioritized_interrupt_controller_bench
